// *** logic/i2cw_core.sv ***
// i2c wakeup, start reservation and start-up control with an axi4-lite register port
//
// Function
// - slave irq only on local or extension address
// - any start enters address standby, masters too
// - wakeup mode receives address, irqs on match
// - reserved start fires after stop, then waits
// - start request: free bus starts, else reserves
// - shift writes before stop ignored when reserved
// - reservation accepted between start and stop
// - reservation disabled: request rejected, no start
// - start failed flag set within 5 clocks
// - initial start off: bus busy after enable
// - initial start on: bus free after enable
// - enable with data low sees start; release exits
// - reserved without stop irq stalls in wait
// - stop irq only with stop irq enable
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "i2cw_consts.svh"
module i2cw_core (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic scl_pin,
    input wire logic sda_pin,
    output logic scl_o,
    output logic scl_oe,
    output logic sda_o,
    output logic sda_oe,
    output logic bus_event_irq
);
    i2cw_pkg::i2cw_line_t line;
    i2cw_pkg::i2cw_state_t state;
    logic aw_hold, w_hold, next_aw_hold, next_w_hold, next_bvalid, next_rvalid;
    logic [7:0] aw_addr;
    logic [7:0] w_data;
    logic w_strb0;
    logic unit_enable, stop_irq_enable, start_request, stop_request;
    logic wakeup_enable, initial_start_enable, reservation_disable;
    logic start_failed_flag, bus_busy_flag, master_status_flag;
    logic start_detected_flag, stop_detected_flag, addr_match_flag, ext_code_flag;
    logic [6:0] local_addr;
    logic [7:0] shift_register, low_width_setting, high_width_setting;
    logic [7:0] cnt;
    logic en_q, rx_active, addr_done, slave_part;
    logic [2:0] rx_cnt;
    logic [7:0] rx_shift;

    i2cw_line_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .scl_pin(scl_pin),
        .sda_pin(sda_pin),
        .line(line)
    );

    function automatic logic is_mapped(input logic [7:0] a);
        return a == `I2CW_OFS_CTRL0 || a == `I2CW_OFS_STATUS || a == `I2CW_OFS_FLAG
            || a == `I2CW_OFS_CTRL1 || a == `I2CW_OFS_LADDR || a == `I2CW_OFS_SHIFT
            || a == `I2CW_OFS_LOWW || a == `I2CW_OFS_HIGHW;
    endfunction

    // ---- axi4-lite slave: address and data taken in either order
    wire aw_fire = awvalid && awready;
    wire w_fire = wvalid && wready;
    wire wr_go = aw_hold && w_hold && !bvalid;
    wire ar_fire = arvalid && arready;
    wire wr_ok = wr_go && w_strb0 && is_mapped(aw_addr);

    function automatic logic wr_sel(input logic [7:0] ofs);
        return wr_ok && aw_addr == ofs;
    endfunction

    always_comb begin
        next_aw_hold = (aw_hold || aw_fire) && !wr_go;
        next_w_hold = (w_hold || w_fire) && !wr_go;
        next_bvalid = wr_go || (bvalid && !bready);
        next_rvalid = ar_fire || (rvalid && !rready);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `I2CW_RESP_OK;
            aw_addr <= 8'h00;
            w_data <= 8'h00;
            w_strb0 <= 1'b0;
        end else begin
            aw_hold <= next_aw_hold;
            w_hold <= next_w_hold;
            awready <= !next_aw_hold && !next_bvalid;
            wready <= !next_w_hold && !next_bvalid;
            bvalid <= next_bvalid;
            if (aw_fire) begin
                aw_addr <= awaddr;
            end
            if (w_fire) begin
                w_data <= wdata[`I2CW_BYTE_MSB:0];
                w_strb0 <= wstrb[0];
            end
            if (wr_go) begin
                bresp <= is_mapped(aw_addr) ? `I2CW_RESP_OK : `I2CW_RESP_ERR;
            end
        end
    end

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            `I2CW_OFS_CTRL0: begin
                r[`I2CW_B_UE] = unit_enable;
                r[`I2CW_B_SPIE] = stop_irq_enable;
                r[`I2CW_B_STT] = start_request;
                r[`I2CW_B_SPT] = stop_request;
            end
            `I2CW_OFS_STATUS: begin
                r[`I2CW_B_MSTS] = master_status_flag;
                r[`I2CW_B_EXC] = ext_code_flag;
                r[`I2CW_B_COI] = addr_match_flag;
                r[`I2CW_B_STD] = start_detected_flag;
                r[`I2CW_B_SPD] = stop_detected_flag;
            end
            `I2CW_OFS_FLAG: begin
                r[`I2CW_B_STCF] = start_failed_flag;
                r[`I2CW_B_BSY] = bus_busy_flag;
                r[`I2CW_B_STCEN] = initial_start_enable;
                r[`I2CW_B_RSV] = reservation_disable;
            end
            `I2CW_OFS_CTRL1: r[`I2CW_B_WUP] = wakeup_enable;
            `I2CW_OFS_LADDR: r[`I2CW_ADDR_MSB:0] = local_addr;
            `I2CW_OFS_SHIFT: r[`I2CW_BYTE_MSB:0] = shift_register;
            `I2CW_OFS_LOWW: r[`I2CW_BYTE_MSB:0] = low_width_setting;
            `I2CW_OFS_HIGHW: r[`I2CW_BYTE_MSB:0] = high_width_setting;
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `I2CW_RESP_OK;
        end else begin
            arready <= !next_rvalid;
            rvalid <= next_rvalid;
            if (ar_fire) begin
                rdata <= rd_mux(araddr);
                rresp <= is_mapped(araddr) ? `I2CW_RESP_OK : `I2CW_RESP_ERR;
            end
        end
    end

    // ---- software controls
    // a function in a continuous assignment only follows its arguments
    logic ctrl0_wr, sh_wr;
    always_comb begin
        ctrl0_wr = wr_sel(`I2CW_OFS_CTRL0);
        sh_wr = wr_sel(`I2CW_OFS_SHIFT);
    end
    wire rel_pulse = ctrl0_wr && w_data[`I2CW_B_LREL];
    wire en_rise = unit_enable && !en_q;
    // enabling while data is low and clock high looks like a start
    wire start_like = line.start || (en_rise && line.scl && !line.sda);
    wire start_take = state == i2cw_pkg::I2CW_IDLE && start_request && unit_enable;
    wire reject = start_take && bus_busy_flag && reservation_disable;
    wire stop_take = stop_request && unit_enable && !start_take
        && (state == i2cw_pkg::I2CW_IDLE || state == i2cw_pkg::I2CW_MAST);
    wire addr_hit = rx_shift[`I2CW_BYTE_MSB:1] == local_addr;
    wire addr_ext = rx_shift[7:4] == `I2CW_EXT_LO || rx_shift[7:4] == `I2CW_EXT_HI;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unit_enable <= 1'b0;
            stop_irq_enable <= 1'b0;
            wakeup_enable <= 1'b0;
            initial_start_enable <= 1'b0;
            reservation_disable <= 1'b0;
            local_addr <= `I2CW_LADDR_RST;
            low_width_setting <= `I2CW_WIDTH_RST;
            high_width_setting <= `I2CW_WIDTH_RST;
            en_q <= 1'b0;
        end else begin
            en_q <= unit_enable;
            if (ctrl0_wr) begin
                unit_enable <= w_data[`I2CW_B_UE];
                stop_irq_enable <= w_data[`I2CW_B_SPIE];
            end
            if (wr_sel(`I2CW_OFS_CTRL1)) begin
                wakeup_enable <= w_data[`I2CW_B_WUP];
            end
            if (wr_sel(`I2CW_OFS_FLAG)) begin
                initial_start_enable <= w_data[`I2CW_B_STCEN];
                reservation_disable <= w_data[`I2CW_B_RSV];
            end
            if (wr_sel(`I2CW_OFS_LADDR)) begin
                local_addr <= w_data[`I2CW_ADDR_MSB:0];
            end
            if (wr_sel(`I2CW_OFS_LOWW)) begin
                low_width_setting <= w_data;
            end
            if (wr_sel(`I2CW_OFS_HIGHW)) begin
                high_width_setting <= w_data;
            end
        end
    end

    // request bits: set by software, cleared once handled; the set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_request <= 1'b0;
            stop_request <= 1'b0;
            start_failed_flag <= 1'b0;
        end else begin
            if (ctrl0_wr && w_data[`I2CW_B_STT] && w_data[`I2CW_B_UE]) begin
                start_request <= 1'b1;
            end else if (start_take || !unit_enable) begin
                start_request <= 1'b0;
            end
            if (ctrl0_wr && w_data[`I2CW_B_SPT] && w_data[`I2CW_B_UE]) begin
                stop_request <= 1'b1;
            end else if (stop_take || !unit_enable) begin
                stop_request <= 1'b0;
            end
            if (reject) begin
                start_failed_flag <= 1'b1;
            end else if (ctrl0_wr && w_data[`I2CW_B_STT]) begin
                start_failed_flag <= 1'b0;
            end
        end
    end

    // shift register: a reserved master ignores data until the stop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_register <= 8'h00;
        end else if (sh_wr && state != i2cw_pkg::I2CW_RSV) begin
            shift_register <= w_data;
        end
    end

    // ---- bus state seen from the lines
    always_ff @(posedge aclk) begin
        if (!aresetn || !unit_enable) begin
            bus_busy_flag <= 1'b0;
            start_detected_flag <= 1'b0;
            stop_detected_flag <= 1'b0;
        end else if (start_like) begin
            bus_busy_flag <= 1'b1;
            start_detected_flag <= 1'b1;
            stop_detected_flag <= 1'b0;
        end else if (line.stop) begin
            bus_busy_flag <= 1'b0;
            start_detected_flag <= 1'b0;
            stop_detected_flag <= 1'b1;
        end else if (en_rise) begin
            bus_busy_flag <= !initial_start_enable;
        end
    end

    // ---- address reception, also while this end is the master
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_active <= 1'b0;
            rx_cnt <= 3'h0;
            rx_shift <= 8'h00;
            addr_done <= 1'b0;
            slave_part <= 1'b0;
            addr_match_flag <= 1'b0;
            ext_code_flag <= 1'b0;
        end else begin
            addr_done <= 1'b0;
            if (!unit_enable || line.stop || rel_pulse) begin
                rx_active <= 1'b0;
                slave_part <= 1'b0;
            end else if (start_like) begin
                rx_active <= 1'b1;
                rx_cnt <= 3'h0;
                slave_part <= 1'b0;
            end else if (rx_active && line.rise) begin
                rx_shift <= {rx_shift[6:0], line.sda};
                rx_cnt <= 3'(rx_cnt + 3'h1);
                if (rx_cnt == `I2CW_LAST_BIT) begin
                    rx_active <= 1'b0;
                    addr_done <= 1'b1;
                end
            end else if (addr_done) begin
                addr_match_flag <= addr_hit;
                ext_code_flag <= addr_ext;
                slave_part <= addr_hit || addr_ext;
            end
        end
    end

    // no operating-clock dependence beyond sampling; wakeup only filters causes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_event_irq <= 1'b0;
        end else begin
            bus_event_irq <= unit_enable && ((addr_done && (addr_hit || addr_ext))
                || (line.stop && stop_irq_enable && !wakeup_enable));
        end
    end

    // ---- master start/stop generator
    always_ff @(posedge aclk) begin
        if (!aresetn || !unit_enable) begin
            state <= i2cw_pkg::I2CW_IDLE;
            cnt <= 8'h00;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
        end else begin
            case (state)
                i2cw_pkg::I2CW_IDLE: begin
                    cnt <= 8'h00;
                    if (start_take && !bus_busy_flag) begin
                        state <= i2cw_pkg::I2CW_SGEN;
                        sda_oe <= 1'b1;
                    end else if (start_take && !reservation_disable) begin
                        state <= i2cw_pkg::I2CW_RSV;
                    end else if (stop_take) begin
                        state <= i2cw_pkg::I2CW_PGEN;
                        sda_oe <= 1'b1;
                        scl_oe <= 1'b1;
                    end
                end
                i2cw_pkg::I2CW_RSV: begin
                    if (line.stop) begin
                        state <= i2cw_pkg::I2CW_SGEN;
                        sda_oe <= 1'b1;
                    end
                end
                i2cw_pkg::I2CW_SGEN: begin
                    cnt <= 8'(cnt + 8'h01);
                    if (cnt >= high_width_setting) begin
                        state <= i2cw_pkg::I2CW_WAIT;
                        scl_oe <= 1'b1;
                    end
                end
                i2cw_pkg::I2CW_WAIT: begin
                    // without a stop irq software may never write here
                    if (sh_wr) begin
                        state <= i2cw_pkg::I2CW_MAST;
                        scl_oe <= 1'b0;
                    end
                end
                i2cw_pkg::I2CW_MAST: begin
                    cnt <= 8'h00;
                    if (stop_take) begin
                        state <= i2cw_pkg::I2CW_PGEN;
                        sda_oe <= 1'b1;
                        scl_oe <= 1'b1;
                    end
                end
                i2cw_pkg::I2CW_PGEN: begin
                    cnt <= 8'(cnt + 8'h01);
                    if (cnt >= low_width_setting) begin
                        state <= i2cw_pkg::I2CW_PREL;
                        scl_oe <= 1'b0;
                        cnt <= 8'h00;
                    end
                end
                i2cw_pkg::I2CW_PREL: begin
                    cnt <= 8'(cnt + 8'h01);
                    if (cnt >= high_width_setting) begin
                        state <= i2cw_pkg::I2CW_IDLE;
                        sda_oe <= 1'b0;
                    end
                end
                default: state <= i2cw_pkg::I2CW_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            master_status_flag <= 1'b0;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            master_status_flag <= state != i2cw_pkg::I2CW_IDLE && state != i2cw_pkg::I2CW_RSV;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
    end

    // ---- checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_MISMATCH_QUIET: assert property (
        addr_done && !addr_hit && !addr_ext && !line.stop |=> !bus_event_irq)
        else $error("irq raised on address mismatch");
    AST_START_STANDBY: assert property (
        unit_enable && start_like && !rel_pulse |=> rx_active)
        else $error("start did not enter address standby");
    AST_WAKE_ADDR_ONLY: assert property (
        bus_event_irq && $past(wakeup_enable) |-> $past(addr_done))
        else $error("wakeup irq without address cause");
    AST_RSV_TO_START: assert property (
        state == i2cw_pkg::I2CW_RSV && line.stop && unit_enable
        |=> state == i2cw_pkg::I2CW_SGEN && sda_oe)
        else $error("reserved start not issued after stop");
    AST_FREE_START: assert property (
        start_take && !bus_busy_flag |=> sda_oe ##1 master_status_flag)
        else $error("free bus start not issued");
    AST_SHIFT_IGNORED: assert property (
        sh_wr && state == i2cw_pkg::I2CW_RSV |=> $stable(shift_register))
        else $error("shift written while reserved");
    AST_REJECT_QUIET: assert property (
        reject |=> (!sda_oe && state == i2cw_pkg::I2CW_IDLE) [*3])
        else $error("rejected request drove the bus");
    AST_FAIL_WITHIN5: assert property (
        $rose(start_request) && bus_busy_flag && reservation_disable
        && state == i2cw_pkg::I2CW_IDLE && unit_enable |-> ##[1:5] start_failed_flag)
        else $error("start failed flag late");
    AST_BUSY_AFTER_EN: assert property (
        en_rise && !start_like |=> bus_busy_flag == !$past(initial_start_enable))
        else $error("busy flag wrong after enable");
    AST_STOP_IRQ: assert property (
        line.stop && unit_enable && stop_irq_enable && !wakeup_enable |=> bus_event_irq)
        else $error("stop irq missing");
    AST_REQ_CLEARS: assert property (
        start_take |=> !start_request)
        else $error("start request not cleared");

    COV_RESERVE: cover property (state == i2cw_pkg::I2CW_RSV ##[1:1000] state == i2cw_pkg::I2CW_WAIT);
    COV_REJECT: cover property (reject);
    COV_ADDR_IRQ: cover property (addr_done && addr_hit ##1 bus_event_irq);
    COV_STOP_GEN: cover property (state == i2cw_pkg::I2CW_PREL ##1 state == i2cw_pkg::I2CW_IDLE);
endmodule // i2cw_core

// *** logic/i2cw_consts.svh ***
// register map, field positions, reset values and counts of the i2c control block
`ifndef I2CW_CONSTS_SVH
`define I2CW_CONSTS_SVH
`define I2CW_OFS_CTRL0 8'h00
`define I2CW_OFS_STATUS 8'h04
`define I2CW_OFS_FLAG 8'h08
`define I2CW_OFS_CTRL1 8'h0C
`define I2CW_OFS_LADDR 8'h10
`define I2CW_OFS_SHIFT 8'h14
`define I2CW_OFS_LOWW 8'h18
`define I2CW_OFS_HIGHW 8'h1C
`define I2CW_B_UE 7
`define I2CW_B_LREL 6
`define I2CW_B_SPIE 4
`define I2CW_B_STT 1
`define I2CW_B_SPT 0
`define I2CW_B_MSTS 7
`define I2CW_B_EXC 5
`define I2CW_B_COI 4
`define I2CW_B_STD 1
`define I2CW_B_SPD 0
`define I2CW_B_STCF 7
`define I2CW_B_BSY 6
`define I2CW_B_STCEN 1
`define I2CW_B_RSV 0
`define I2CW_B_WUP 0
`define I2CW_ADDR_MSB 6
`define I2CW_BYTE_MSB 7
`define I2CW_RESP_OK 2'h0
`define I2CW_RESP_ERR 2'h2
`define I2CW_WIDTH_RST 8'h10
`define I2CW_LADDR_RST 7'h00
`define I2CW_LINE_IDLE 2'h3
`define I2CW_LINE_RST 5'h18
`define I2CW_LAST_BIT 3'h7
`define I2CW_EXT_LO 4'h0
`define I2CW_EXT_HI 4'hF
`endif

// *** logic/i2cw_pkg.sv ***
// types shared by the i2c control block
package i2cw_pkg;
    typedef enum logic [2:0] {
        I2CW_IDLE = 3'b000,
        I2CW_RSV = 3'b001,
        I2CW_SGEN = 3'b010,
        I2CW_WAIT = 3'b011,
        I2CW_MAST = 3'b100,
        I2CW_PGEN = 3'b101,
        I2CW_PREL = 3'b110
    } i2cw_state_t;
    typedef struct packed {
        logic scl;
        logic sda;
        logic start;
        logic stop;
        logic rise;
    } i2cw_line_t;
endpackage

// *** logic/i2cw_line_sync.sv ***
// synchroniser and start/stop/edge detector for the two bus lines
`timescale 1ns/1ps
`include "i2cw_consts.svh"
module i2cw_line_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic scl_pin,
    input wire logic sda_pin,
    output i2cw_pkg::i2cw_line_t line
);
    logic [1:0] scl_ff;
    logic [1:0] sda_ff;

    // first stage is read only by the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_ff <= `I2CW_LINE_IDLE;
            sda_ff <= `I2CW_LINE_IDLE;
        end else begin
            scl_ff <= {scl_ff[0], scl_pin};
            sda_ff <= {sda_ff[0], sda_pin};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line <= `I2CW_LINE_RST;
        end else begin
            line.scl <= scl_ff[1];
            line.sda <= sda_ff[1];
            line.start <= line.scl && scl_ff[1] && line.sda && !sda_ff[1];
            line.stop <= line.scl && scl_ff[1] && !line.sda && sda_ff[1];
            line.rise <= !line.scl && scl_ff[1];
        end
    end
endmodule // i2cw_line_sync

// *** tb/i2cw_bus_model.sv ***
// far-side i2c master model driving the open-drain lines
`timescale 1ns/1ps
module i2cw_bus_model (
    output logic scl_drv,
    output logic sda_drv
);
    // 1 = released; the pull-up sets the level, and the clock stands still between frames
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic start_cond();
        sda_drv = 1'b0;
        #80;
        scl_drv = 1'b0;
        #40;
    endtask
    // data held low while the clock stays high, as on a bus already in use
    task automatic data_low();
        sda_drv = 1'b0;
        #40;
    endtask
    task automatic stop_cond();
        sda_drv = 1'b0;
        #40;
        scl_drv = 1'b1;
        #80;
        sda_drv = 1'b1;
        #80;
    endtask
    // msb first, data changes only while the clock is low, 160 ns per bit
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sda_drv = b[i];
            #40;
            scl_drv = 1'b1;
            #80;
            scl_drv = 1'b0;
            #40;
        end
    endtask
endmodule // i2cw_bus_model

// *** tb/i2c_wakeup_start_reservation_tb.sv ***
// register-level bench of the i2c control block against a bus model
`timescale 1ns/1ps
`include "i2cw_consts.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s exp %h got %h", n, e, g); end end
module i2c_wakeup_start_reservation_tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, scl_o, scl_oe, sda_o, sda_oe, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rd_r, wr_r;
    logic scl_drv, sda_drv, scl_pin, sda_pin;
    int bad_count, comparisons, irqs, cyc, n0;
    assign scl_pin = scl_drv & ~scl_oe;
    assign sda_pin = sda_drv & ~sda_oe;
    i2cw_core i_i2cw_core (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .scl_pin(scl_pin), .sda_pin(sda_pin), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_o(sda_o), .sda_oe(sda_oe), .bus_event_irq(irq));
    i2cw_bus_model i_i2cw_bus_model (.scl_drv(scl_drv), .sda_drv(sda_drv));
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (irq === 1'b1) irqs++;
        cyc++;
        // the whole sequence needs under a thousand cycles
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic close_out();
        if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bit b_d;
        b_d = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_d) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                b_d = 1;
                wr_r = bresp;
                bready <= 1'b0;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a);
        bit r_d;
        r_d = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_d) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                r_d = 1;
                rd_d = rdata;
                rd_r = rresp;
                rready <= 1'b0;
            end
        end
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hF;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(`I2CW_OFS_LOWW);
        `CHK("low width", 32'h00000010, rd_d)
        rd(8'h20);
        `CHK("unmapped", `I2CW_RESP_ERR, rd_r)
        wr(8'h24, 8'h01);
        `CHK("unmapped write", `I2CW_RESP_ERR, wr_r)
        wr(`I2CW_OFS_FLAG, 8'h02);
        `CHK("mapped write", `I2CW_RESP_OK, wr_r)
        wr(`I2CW_OFS_LADDR, 8'h2A);
        wr(`I2CW_OFS_CTRL0, 8'h90);
        rd(`I2CW_OFS_FLAG);
        `CHK("free after enable", 8'h02, rd_d[7:0])
        i_i2cw_bus_model.start_cond();
        i_i2cw_bus_model.send_byte(8'h54);
        repeat (10) @(posedge aclk);
        `CHK("match irq", 1, irqs)
        i_i2cw_bus_model.stop_cond();
        repeat (10) @(posedge aclk);
        `CHK("stop irq", 2, irqs)
        i_i2cw_bus_model.start_cond();
        i_i2cw_bus_model.send_byte(8'hAA);
        repeat (10) @(posedge aclk);
        `CHK("mismatch no irq", 2, irqs)
        wr(`I2CW_OFS_CTRL0, 8'h92);
        repeat (36) @(posedge aclk);
        rd(`I2CW_OFS_STATUS);
        `CHK("reserved, not master", 1'b0, rd_d[7])
        `CHK("no start while busy", 1'b0, sda_oe)
        wr(`I2CW_OFS_SHIFT, 8'h54); // dropped: stop not yet seen
        i_i2cw_bus_model.stop_cond();
        repeat (40) @(posedge aclk);
        rd(`I2CW_OFS_STATUS);
        `CHK("master after stop", 1'b1, rd_d[7])
        `CHK("start driven", 1'b1, sda_oe)
        `CHK("wait state held", 1'b1, scl_oe)
        wr(`I2CW_OFS_SHIFT, 8'h54);
        repeat (4) @(posedge aclk);
        `CHK("wait released", 1'b0, scl_oe)
        wr(`I2CW_OFS_CTRL0, 8'h91);
        repeat (80) @(posedge aclk);
        `CHK("stop done sda", 1'b0, sda_oe)
        rd(`I2CW_OFS_CTRL0);
        `CHK("requests cleared", 8'h90, rd_d[7:0])
        wr(`I2CW_OFS_FLAG, 8'h03);
        i_i2cw_bus_model.start_cond();
        wr(`I2CW_OFS_CTRL0, 8'h82);
        repeat (5) @(posedge aclk);
        rd(`I2CW_OFS_FLAG);
        `CHK("start failed", 8'hC3, rd_d[7:0])
        `CHK("no start issued", 1'b0, sda_oe)
        n0 = irqs;
        i_i2cw_bus_model.stop_cond();
        repeat (10) @(posedge aclk);
        `CHK("stop irq masked", n0, irqs)
        wr(`I2CW_OFS_CTRL0, 8'h00);
        wr(`I2CW_OFS_FLAG, 8'h00);
        wr(`I2CW_OFS_CTRL0, 8'h80);
        rd(`I2CW_OFS_FLAG);
        `CHK("busy after enable", 8'hC0, rd_d[7:0])
        wr(`I2CW_OFS_CTRL0, 8'h00);
        wr(`I2CW_OFS_FLAG, 8'h02);
        i_i2cw_bus_model.data_low();
        wr(`I2CW_OFS_CTRL0, 8'h80);
        repeat (4) @(posedge aclk);
        wr(`I2CW_OFS_CTRL0, 8'hC0);
        rd(`I2CW_OFS_STATUS);
        `CHK("start seen at enable", 8'h02, rd_d[7:0])
        n0 = irqs;
        i_i2cw_bus_model.start_cond();
        i_i2cw_bus_model.send_byte(8'h00);
        repeat (10) @(posedge aclk);
        `CHK("released reception", n0, irqs)
        i_i2cw_bus_model.stop_cond();
        wr(`I2CW_OFS_CTRL0, 8'h90);
        wr(`I2CW_OFS_CTRL1, 8'h01);
        repeat (3) @(posedge aclk);
        n0 = irqs;
        i_i2cw_bus_model.start_cond();
        i_i2cw_bus_model.send_byte(8'h00);
        repeat (10) @(posedge aclk);
        `CHK("wakeup irq", n0 + 1, irqs)
        wr(`I2CW_OFS_CTRL1, 8'h00);
        repeat (5) @(posedge aclk);
        rd(`I2CW_OFS_STATUS);
        `CHK("extension status", 8'h22, rd_d[7:0])
        i_i2cw_bus_model.stop_cond();
        repeat (10) @(posedge aclk);
        `CHK("stop irq after wakeup", n0 + 2, irqs)
        wr(`I2CW_OFS_CTRL0, 8'h92);
        repeat (36) @(posedge aclk);
        rd(`I2CW_OFS_STATUS);
        `CHK("free start master", 1'b1, rd_d[7])
        `CHK("free start wait", 1'b1, scl_oe)
        `CHK("open drain level", 2'h0, {scl_o, sda_o})
        close_out();
    end
endmodule // i2c_wakeup_start_reservation_tb
